// ==== verification/sstm_bt_checker.sv ====
/*
  Checker on the block-transfer link between the two ends.
  Assumes ce held high and the host sending whole 64-word blocks.
*/
`timescale 1ns/100ps
`include "sstm_defs.svh"
module sstm_bt_checker (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link
  input wire logic wr_valid,
  input wire sstm_pkg::sstm_word_t wr_data,
  input wire logic rd_valid,
  input wire logic rd_last,
  input wire sstm_pkg::sstm_word_t rd_data
);
  import sstm_pkg::*;
  logic [5:0] wc_q;
  logic [5:0] rc_q;
  logic rep_q;
  sstm_word_t code_q;
  sstm_word_t ofs;
  logic known;
  logic is_en;
  logic is_stat;
  logic w_end;
  //////////////////////////////////////////////////////////////////////
  assign ofs = code_q - (code_q >= `SSTM_BASE_P2 ? `SSTM_BASE_P2
                                                  : `SSTM_BASE_P1);
  assign known = code_q >= `SSTM_BASE_P1 && ofs <= `SSTM_OFS_STAT_HI;
  assign is_en = known && ofs == `SSTM_OFS_EN;
  assign is_stat = known && ofs >= `SSTM_OFS_STAT_LO;
  assign w_end = wr_valid && !rep_q && wc_q == `SSTM_W_LAST;
  // mirrors the device word count; words during a reply are dropped
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wc_q <= 6'h00;
      rc_q <= 6'h00;
      rep_q <= 1'h0;
      code_q <= 16'h0000;
    end else begin
      if (wr_valid && !rep_q) begin
        wc_q <= wc_q + 6'h01;
      end
      if (wr_valid && !rep_q && wc_q == `SSTM_W_CODE) begin
        code_q <= wr_data;
      end
      if (w_end && known) begin
        rep_q <= 1'h1;
      end else if (rd_last) begin
        rep_q <= 1'h0;
      end
      if (rd_valid) begin
        rc_q <= rc_q + 6'h01;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  reply_start_a:
  assert property (w_end && known |-> ##[1:2] (rd_valid && rc_q == 6'h00))
    else $error("reply did not start after word 63");
  reply_burst_a:
  assert property (rd_valid && !rd_last |=> rd_valid)
    else $error("reply words not back to back");
  last_word_a:
  assert property (rd_valid |-> rd_last == (rc_q == `SSTM_W_LAST))
    else $error("rd_last not on word 63");
  code_echo_a:
  assert property (rd_valid && rc_q == 6'h00 && !is_en |-> rd_data == code_q)
    else $error("word 0 not the received code");
  en_reserved_a:
  assert property (rd_valid && rc_q == 6'h00 && is_en |-> rd_data == 16'h0000)
    else $error("enable reply word 0 not zero");
  id_echo_a:
  assert property (rd_valid && rc_q == `SSTM_W_ID |-> rd_data == code_q)
    else $error("word 1 not the block identifier");
  stat_range_a:
  assert property (rd_valid && is_stat && rc_q >= `SSTM_W_LIST_LO
                   |-> rd_data < 16'h0004)
    else $error("state value out of range");
  stat_spare_a:
  assert property (rd_valid && is_stat && rc_q > `SSTM_W_LIST_HI
                   |-> rd_data == 16'h0000)
    else $error("status spare word not zero");
  last_page_a:
  assert property (rd_valid && is_stat && ofs == `SSTM_OFS_STAT_HI
                   && rc_q >= 6'h12 |-> rd_data == 16'h0000)
    else $error("slot beyond 255 not zero");
  count_clamp_a:
  assert property (rd_valid && !is_stat && rc_q == 6'h02
                   |-> rd_data <= `SSTM_LIST_MAX)
    else $error("processed count above sixty");
  stat_blank_a:
  assert property (wr_valid && !rep_q && is_stat && wc_q != `SSTM_W_CODE
                   |-> wr_data == 16'h0000)
    else $error("status request spare word not zero");
endmodule

// ==== verification/tb_slave_status_table_manager.sv ====
/*
  Bench joining host end and table end over one link; scanner events
  driven directly, table checked through status page requests.
  Assumes the design files and the link checker are compiled first.
*/
`timescale 1ns/100ps
`include "sstm_defs.svh"
module tb_slave_status_table_manager;
  import sstm_pkg::*;
  logic ref_clk, reset, ce;
  logic init_start, init_mark, init_port, fail_valid, fail_port;
  logic scan_valid, scan_port, scan_done, scan_go;
  logic [7:0] init_addr, fail_addr, scan_addr, scan_delay, req_base;
  logic req_valid, req_port, busy, rsp_valid, stat_valid;
  sstm_kind_t req_kind;
  logic [2:0] req_page;
  logic [15:0] req_count;
  sstm_word_t rsp_code, rsp_id, rsp_count;
  logic [7:0] stat_addr;
  sstm_state_t stat_state;
  sstm_state_t exp_st [0:1][0:255];
  int num_errors, checks_done, slots;
  //////////////////////////////////////////////////////////////////////
  sstm_bt_if bt (.ref_clk(ref_clk));
  sstm_device #(.DELAY_W(8)) i_sstm_device (.ref_clk(ref_clk),
    .reset(reset), .ce(ce), .bt(bt), .init_start(init_start),
    .init_mark(init_mark), .init_port(init_port), .init_addr(init_addr),
    .fail_valid(fail_valid), .fail_port(fail_port),
    .fail_addr(fail_addr), .scan_delay(scan_delay),
    .scan_valid(scan_valid), .scan_port(scan_port),
    .scan_addr(scan_addr), .scan_done(scan_done), .scan_go(scan_go));
  sstm_host i_sstm_host (.ref_clk(ref_clk), .reset(reset), .ce(ce),
    .bt(bt), .req_valid(req_valid), .req_kind(req_kind),
    .req_port(req_port), .req_page(req_page), .req_count(req_count),
    .req_base(req_base), .busy(busy), .rsp_valid(rsp_valid),
    .rsp_code(rsp_code), .rsp_id(rsp_id), .rsp_count(rsp_count),
    .stat_valid(stat_valid), .stat_addr(stat_addr),
    .stat_state(stat_state));
  sstm_bt_checker i_sstm_bt_checker (.ref_clk(ref_clk), .reset(reset),
    .wr_valid(bt.wr_valid), .wr_data(bt.wr_data),
    .rd_valid(bt.rd_valid), .rd_last(bt.rd_last), .rd_data(bt.rd_data));
  //////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // every status slot seen on the way is compared with the model
  task automatic request(sstm_kind_t k, logic p, logic [2:0] pg,
      logic [15:0] cnt, logic [7:0] b);
    int n;
    req_kind = k;
    req_port = p;
    req_page = pg;
    req_count = cnt;
    req_base = b;
    req_valid = 1'h1;
    @(negedge ref_clk);
    req_valid = 1'h0;
    check("busy", 1'h1, busy);
    slots = 0;
    for (n = 0; n < 400 && rsp_valid !== 1'h1; n++) begin
      @(negedge ref_clk);
      if (stat_valid === 1'h1) begin
        slots++;
        check("slave state", exp_st[p][stat_addr], stat_state);
      end
    end
    if (n == 400) begin
      num_errors++;
      end_sim();
    end
    check("busy idle", 1'h0, busy);
    @(negedge ref_clk);
  endtask
  task automatic read_all();
    logic [15:0] c;
    for (int p = 0; p < 2; p++) begin
      for (int pg = 0; pg < 5; pg++) begin
        c = (p ? `SSTM_BASE_P2 : `SSTM_BASE_P1) + `SSTM_OFS_STAT_LO + pg;
        request(SSTM_K_STAT, p[0], pg[2:0], 16'h0000, 8'h00);
        check("page code", c, rsp_code);
        check("page id", c, rsp_id);
        check("page slots", pg == 4 ? 16 : 60, slots);
      end
    end
  endtask
  task automatic lst(sstm_kind_t k, logic p, logic [15:0] cnt,
      logic [7:0] b);
    int done;
    logic [15:0] c;
    done = 0;
    c = (p ? `SSTM_BASE_P2 : `SSTM_BASE_P1)
      + (k == SSTM_K_EN ? `SSTM_OFS_EN : `SSTM_OFS_DIS);
    for (int i = 0; i < cnt && i < `SSTM_LIST_MAX; i++) begin
      if (b + i <= `SSTM_MAX_ADDR) begin
        exp_st[p][b + i] = k == SSTM_K_EN ? `SSTM_ST_ACTIVE
                                         : `SSTM_ST_DISABLED;
        done++;
      end
    end
    request(k, p, 3'h0, cnt, b);
    check("reply code", k == SSTM_K_EN ? 16'h0000 : c, rsp_code);
    check("reply id", c, rsp_id);
    check("processed", done, rsp_count);
  endtask
  task automatic sc(logic p, logic [7:0] a, logic go);
    int n;
    scan_port = p;
    scan_addr = a;
    scan_valid = 1'h1;
    @(negedge ref_clk);
    scan_valid = 1'h0;
    for (n = 0; n < 4 && scan_done !== 1'h1; n++) begin
      @(negedge ref_clk);
    end
    check("scan done", 1'h1, scan_done);
    check("scan go", go, scan_go);
    @(negedge ref_clk);
  endtask
  task automatic mark(logic p, logic [7:0] a, logic st);
    init_port = p;
    init_addr = a;
    init_start = st;
    init_mark = !st;
    @(negedge ref_clk);
    init_start = 1'h0;
    init_mark = 1'h0;
    if (!st) begin
      exp_st[p][a] = `SSTM_ST_ACTIVE;
    end
    @(negedge ref_clk);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    {reset, ce} = 2'h3;
    {init_start, init_mark, init_port, fail_valid, fail_port} = 5'h00;
    {scan_valid, scan_port, req_valid, req_port} = 4'h0;
    {init_addr, fail_addr, scan_addr, scan_delay, req_base} = 40'h0;
    req_kind = SSTM_K_NONE;
    req_page = 3'h0;
    req_count = 16'h0000;
    num_errors = 0;
    checks_done = 0;
    exp_st = '{default: `SSTM_ST_INACT};
    repeat (20) @(negedge ref_clk);
    reset = 1'h0;
    read_all();
    mark(1'h0, 8'h00, 1'h1);
    mark(1'h1, 8'h00, 1'h1);
    mark(1'h0, 8'h05, 1'h0);
    mark(1'h0, 8'h46, 1'h0);
    mark(1'h0, 8'hfa, 1'h0);
    mark(1'h1, 8'h64, 1'h0);
    read_all();
    // delay of 3: two scans keep it held, the third frees it
    fail_port = 1'h0;
    fail_addr = 8'h05;
    scan_delay = 8'h03;
    fail_valid = 1'h1;
    @(negedge ref_clk);
    fail_valid = 1'h0;
    exp_st[0][5] = `SSTM_ST_SUSP;
    sc(1'h0, 8'h05, 1'h0);
    sc(1'h0, 8'h05, 1'h0);
    request(SSTM_K_STAT, 1'h0, 3'h0, 16'h0000, 8'h00);
    sc(1'h0, 8'h05, 1'h0);
    exp_st[0][5] = `SSTM_ST_ACTIVE;
    sc(1'h0, 8'h05, 1'h1);
    sc(1'h1, 8'h65, 1'h0);
    lst(SSTM_K_DIS, 1'h0, 16'h0004, 8'h44);
    sc(1'h0, 8'h46, 1'h0);
    lst(SSTM_K_EN, 1'h0, 16'h0046, 8'h46);
    sc(1'h0, 8'h46, 1'h1);
    // ce low: a scan and a failure must leave no trace
    ce = 1'h0;
    {fail_port, fail_addr, fail_valid} = {1'h0, 8'h46, 1'h1};
    {scan_port, scan_addr, scan_valid} = {1'h0, 8'h46, 1'h1};
    @(negedge ref_clk);
    check("frozen scan", 1'h0, scan_done);
    {fail_valid, scan_valid} = 2'h0;
    ce = 1'h1;
    sc(1'h0, 8'h46, 1'h1);
    lst(SSTM_K_DIS, 1'h1, 16'h000a, 8'hfa);
    // a failure on a disabled slave must not move it to suspended
    {fail_port, fail_addr, fail_valid} = {1'h1, 8'hfa, 1'h1};
    @(negedge ref_clk);
    fail_valid = 1'h0;
    read_all();
    // mid-run reset empties the whole table
    reset = 1'h1;
    repeat (2) @(negedge ref_clk);
    reset = 1'h0;
    exp_st = '{default: `SSTM_ST_INACT};
    read_all();
    end_sim();
  end
endmodule

// ==== verilog/sstm_bt_if.sv ====
/*
  Block-transfer link between the host processor end and the status
  table end: a write word stream and a read word stream.
  Assumes both ends run on ref_clk; the read stream is never stalled.
*/
`timescale 1ns/100ps
interface sstm_bt_if (
  input wire logic ref_clk
);
  // host to device
  logic wr_valid;
  sstm_pkg::sstm_word_t wr_data;
  // device to host
  logic rd_valid;
  logic rd_last;
  sstm_pkg::sstm_word_t rd_data;

  modport dev (
    input ref_clk,
    input wr_valid,
    input wr_data,
    output rd_valid,
    output rd_last,
    output rd_data
  );
  modport host (
    input ref_clk,
    output wr_valid,
    output wr_data,
    input rd_valid,
    input rd_last,
    input rd_data
  );
endinterface

// ==== verilog/sstm_defs.svh ====
/*
  Constants of the slave status table: block codes, word positions,
  slave state codes and page geometry.
  Assumes 16-bit block-transfer words and 256 slaves per master port.
*/
`ifndef SSTM_DEFS_SVH
`define SSTM_DEFS_SVH

// block code bases, one per master port
`define SSTM_BASE_P1 16'h0bb8
`define SSTM_BASE_P2 16'h0c1c
// code offsets from a port base
`define SSTM_OFS_DIS 16'h0000
`define SSTM_OFS_EN 16'h0001
`define SSTM_OFS_STAT_LO 16'h0002
`define SSTM_OFS_STAT_HI 16'h0006
// word positions inside a 64-word block
`define SSTM_W_CODE 6'h00
`define SSTM_W_ID 6'h01
`define SSTM_W_LIST_LO 6'h02
`define SSTM_W_LIST_HI 6'h3d
`define SSTM_W_LAST 6'h3f
// page and list geometry
`define SSTM_PAGE_SLOTS 9'h03c
`define SSTM_LIST_MAX 16'h003c
`define SSTM_MAX_ADDR 16'h00ff
// slave state codes
`define SSTM_ST_INACT 2'h0
`define SSTM_ST_ACTIVE 2'h1
`define SSTM_ST_SUSP 2'h2
`define SSTM_ST_DISABLED 2'h3

`endif

// ==== verilog/sstm_device.sv ====
/*
  Status table end: per-port slave state table with suspension delay
  counters, driven by command-scanner events, and a block-transfer
  responder for status pages and disable/enable blocks.
  Assumes the host sends whole 64-word blocks and takes every read word.
*/
`timescale 1ns/100ps
`include "sstm_defs.svh"

module sstm_device #(
  parameter int DELAY_W = 8
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // block-transfer link
  sstm_bt_if.dev bt,
  // list initialisation
  input wire logic init_start,
  input wire logic init_mark,
  input wire logic init_port,
  input wire logic [7:0] init_addr,
  // retry expiry
  input wire logic fail_valid,
  input wire logic fail_port,
  input wire logic [7:0] fail_addr,
  input wire logic [DELAY_W-1:0] scan_delay,
  // command scanner
  input wire logic scan_valid,
  input wire logic scan_port,
  input wire logic [7:0] scan_addr,
  output logic scan_done,
  output logic scan_go
);
  import sstm_pkg::*;

  typedef struct packed {
    sstm_dev_phase_t phase;
    logic [5:0] widx;
    logic [5:0] ridx;
    sstm_word_t code;
    sstm_kind_t kind;
    logic port;
    logic [2:0] page;
    logic [5:0] cnt;
    logic [5:0] done;
    logic rd_valid;
    logic rd_last;
    sstm_word_t rd_data;
    logic scan_done;
    logic scan_go;
    logic [1:0][255:0][1:0] st;
    logic [1:0][255:0][DELAY_W-1:0] dly;
  } sstm_dev_state_t;

  sstm_dev_state_t q;
  sstm_dev_state_t d;

  assign bt.rd_valid = q.rd_valid;
  assign bt.rd_last = q.rd_last;
  assign bt.rd_data = q.rd_data;
  assign scan_done = q.scan_done;
  assign scan_go = q.scan_go;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    sstm_word_t sub1;
    sstm_word_t sub2;
    sstm_word_t sub;
    logic [8:0] a;
    logic [5:0] li;
    sstm_state_t cur;
    sub1 = '0;
    sub2 = '0;
    sub = '0;
    a = '0;
    li = '0;
    cur = '0;
    d = q;
    d.rd_valid = 1'b0;
    d.rd_last = 1'b0;
    d.scan_done = 1'b0;
    d.scan_go = 1'b0;

    // scanner-side events; later ones win on the same slave
    if (init_start) begin
      d.st[init_port] = '0;
      d.dly[init_port] = '0;
    end
    if (init_mark) begin
      d.st[init_port][init_addr] = `SSTM_ST_ACTIVE;
    end
    if (fail_valid &&
        d.st[fail_port][fail_addr] != `SSTM_ST_DISABLED) begin
      d.st[fail_port][fail_addr] = `SSTM_ST_SUSP;
      d.dly[fail_port][fail_addr] = scan_delay;
    end
    if (scan_valid) begin
      cur = d.st[scan_port][scan_addr];
      d.scan_done = 1'b1;
      // only healthy slaves are polled; 0, 2 and 3 are held off
      d.scan_go = (cur == `SSTM_ST_ACTIVE);
      if (cur == `SSTM_ST_SUSP) begin
        // a zero or one count expires on this scan
        if (d.dly[scan_port][scan_addr] <= DELAY_W'(1)) begin
          d.dly[scan_port][scan_addr] = '0;
          d.st[scan_port][scan_addr] = `SSTM_ST_ACTIVE;
        end else begin
          d.dly[scan_port][scan_addr] =
            d.dly[scan_port][scan_addr] - DELAY_W'(1);
        end
      end
    end

    ////////////////////////////////////////////////////////////////////
    // block-transfer side

    unique case (q.phase)
      SSTM_D_RECV: begin
        // writes during a reply are dropped, see the reply branch
        if (bt.wr_valid) begin
          d.widx = q.widx + 6'h01;
          if (q.widx == `SSTM_W_CODE) begin
            sub1 = bt.wr_data - `SSTM_BASE_P1;
            sub2 = bt.wr_data - `SSTM_BASE_P2;
            d.code = bt.wr_data;
            d.done = '0;
            d.kind = SSTM_K_NONE;
            d.port = sub1 > `SSTM_OFS_STAT_HI;
            sub = d.port ? sub2 : sub1;
            if (sub <= `SSTM_OFS_STAT_HI) begin
              if (sub == `SSTM_OFS_DIS) begin
                d.kind = SSTM_K_DIS;
              end else if (sub == `SSTM_OFS_EN) begin
                d.kind = SSTM_K_EN;
              end else begin
                d.kind = SSTM_K_STAT;
              end
            end
            d.page = 3'(sub - `SSTM_OFS_STAT_LO);
          end else if (q.widx == `SSTM_W_ID) begin
            d.cnt = (bt.wr_data > `SSTM_LIST_MAX) ?
              6'(`SSTM_LIST_MAX) : bt.wr_data[5:0];
          end else if (q.widx <= `SSTM_W_LIST_HI) begin
            li = q.widx - `SSTM_W_LIST_LO;
            if ((q.kind == SSTM_K_DIS || q.kind == SSTM_K_EN) &&
                li < q.cnt && bt.wr_data <= `SSTM_MAX_ADDR) begin
              d.st[q.port][bt.wr_data[7:0]] = (q.kind == SSTM_K_DIS) ?
                `SSTM_ST_DISABLED : `SSTM_ST_ACTIVE;
              d.dly[q.port][bt.wr_data[7:0]] = '0;
              d.done = q.done + 6'h01;
            end
          end
          // block length fixed at 64 words
          if (q.widx == `SSTM_W_LAST && q.kind != SSTM_K_NONE) begin
            d.phase = SSTM_D_REPLY;
            d.ridx = '0;
          end
        end
      end
      SSTM_D_REPLY: begin
        d.rd_valid = 1'b1;
        d.rd_last = (q.ridx == `SSTM_W_LAST);
        d.ridx = q.ridx + 6'h01;
        d.rd_data = '0;
        if (q.ridx == `SSTM_W_CODE) begin
          // enable reply leaves word 0 reserved as zero
          d.rd_data = (q.kind == SSTM_K_EN) ? '0 : q.code;
        end else if (q.ridx == `SSTM_W_ID) begin
          d.rd_data = q.code;
        end else if (q.kind == SSTM_K_STAT) begin
          if (q.ridx <= `SSTM_W_LIST_HI) begin
            a = 9'(q.page) * `SSTM_PAGE_SLOTS + 9'(q.ridx) -
              9'(`SSTM_W_LIST_LO);
            if (a <= 9'(`SSTM_MAX_ADDR)) begin
              d.rd_data = 16'(q.st[q.port][a[7:0]]);
            end // slots past 255 stay zero
          end
        end else if (q.ridx == `SSTM_W_LIST_LO) begin
          d.rd_data = 16'(q.done);
        end
        if (q.ridx == `SSTM_W_LAST) begin
          d.phase = SSTM_D_RECV;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0; // every slave inactive
    end else if (ce) begin
      q <= d;
    end
  end
endmodule

// ==== verilog/sstm_host.sv ====
/*
  Host processor end: builds 64-word status, disable and enable blocks
  from one user request and unpacks the reply block.
  Assumes the device end answers each recognised block with 64 words.
*/
`timescale 1ns/100ps
`include "sstm_defs.svh"

module sstm_host (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic ce,
  // block-transfer link
  sstm_bt_if.host bt,
  // user request
  input wire logic req_valid,
  input wire sstm_pkg::sstm_kind_t req_kind,
  input wire logic req_port,
  input wire logic [2:0] req_page,
  input wire logic [15:0] req_count,
  input wire logic [7:0] req_base,
  output logic busy,
  // reply summary
  output logic rsp_valid,
  output sstm_pkg::sstm_word_t rsp_code,
  output sstm_pkg::sstm_word_t rsp_id,
  output sstm_pkg::sstm_word_t rsp_count,
  // status stream
  output logic stat_valid,
  output logic [7:0] stat_addr,
  output sstm_pkg::sstm_state_t stat_state
);
  import sstm_pkg::*;

  typedef struct packed {
    sstm_host_phase_t phase;
    logic busy;
    logic [5:0] idx;
    sstm_kind_t kind;
    sstm_word_t code;
    sstm_word_t count;
    logic [7:0] base;
    logic [2:0] page;
    logic wr_valid;
    sstm_word_t wr_data;
    logic rsp_valid;
    sstm_word_t rsp_code;
    sstm_word_t rsp_id;
    sstm_word_t rsp_count;
    logic stat_valid;
    logic [7:0] stat_addr;
    sstm_state_t stat_state;
  } sstm_host_state_t;

  sstm_host_state_t q;
  sstm_host_state_t d;

  assign bt.wr_valid = q.wr_valid;
  assign bt.wr_data = q.wr_data;
  assign busy = q.busy;
  assign rsp_valid = q.rsp_valid;
  assign rsp_code = q.rsp_code;
  assign rsp_id = q.rsp_id;
  assign rsp_count = q.rsp_count;
  assign stat_valid = q.stat_valid;
  assign stat_addr = q.stat_addr;
  assign stat_state = q.stat_state;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    sstm_word_t ofs;
    sstm_word_t li;
    logic [8:0] a;
    ofs = '0;
    li = '0;
    a = '0;
    d = q;
    d.wr_valid = 1'b0;
    d.rsp_valid = 1'b0;
    d.stat_valid = 1'b0;
    unique case (q.phase)
      SSTM_H_IDLE: begin
        if (req_valid && req_kind != SSTM_K_NONE) begin
          unique case (req_kind)
            SSTM_K_DIS: ofs = `SSTM_OFS_DIS;
            SSTM_K_EN: ofs = `SSTM_OFS_EN;
            default: ofs = `SSTM_OFS_STAT_LO + 16'(req_page);
          endcase
          d.code = (req_port ? `SSTM_BASE_P2 : `SSTM_BASE_P1) + ofs;
          d.kind = req_kind;
          d.count = req_count;
          d.base = req_base;
          d.page = req_page;
          d.idx = '0;
          d.phase = SSTM_H_SEND;
        end
      end
      SSTM_H_SEND: begin
        d.wr_valid = 1'b1;
        d.wr_data = '0; // unused words are zero
        li = 16'(q.idx) - 16'(`SSTM_W_LIST_LO);
        if (q.idx == `SSTM_W_CODE) begin
          d.wr_data = q.code;
        end else if (q.kind != SSTM_K_STAT) begin
          if (q.idx == `SSTM_W_ID) begin
            d.wr_data = q.count;
          end else if (q.idx <= `SSTM_W_LIST_HI && li < q.count) begin
            d.wr_data = 16'(q.base) + li;
          end
        end
        d.idx = q.idx + 6'h01;
        if (q.idx == `SSTM_W_LAST) begin
          d.phase = SSTM_H_WAIT;
          d.idx = '0;
        end
      end
      SSTM_H_WAIT: begin
        if (bt.rd_valid) begin
          d.idx = q.idx + 6'h01;
          if (q.idx == `SSTM_W_CODE) begin
            d.rsp_code = bt.rd_data;
          end else if (q.idx == `SSTM_W_ID) begin
            d.rsp_id = bt.rd_data;
          end else if (q.kind == SSTM_K_STAT) begin
            a = 9'(q.page) * `SSTM_PAGE_SLOTS + 9'(q.idx) -
              9'(`SSTM_W_LIST_LO);
            if (q.idx <= `SSTM_W_LIST_HI && a <= 9'(`SSTM_MAX_ADDR)) begin
              d.stat_valid = 1'b1;
              d.stat_addr = a[7:0];
              d.stat_state = bt.rd_data[1:0];
            end
          end else if (q.idx == `SSTM_W_LIST_LO) begin
            d.rsp_count = bt.rd_data;
          end
          if (bt.rd_last) begin
            d.rsp_valid = 1'b1;
            d.phase = SSTM_H_IDLE;
          end
        end
      end
      default: d.phase = SSTM_H_IDLE;
    endcase
    d.busy = (d.phase != SSTM_H_IDLE);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end
endmodule

// ==== verilog/sstm_pkg.sv ====
/*
  Types shared by both ends of the slave status block link.
  Assumes the constants of sstm_defs.svh for codes and positions.
*/
package sstm_pkg;
  typedef logic [15:0] sstm_word_t;
  typedef logic [1:0] sstm_state_t;
  typedef enum logic [1:0] {
    SSTM_K_NONE,
    SSTM_K_DIS,
    SSTM_K_EN,
    SSTM_K_STAT
  } sstm_kind_t;
  typedef enum logic {SSTM_D_RECV, SSTM_D_REPLY} sstm_dev_phase_t;
  typedef enum logic [1:0] {
    SSTM_H_IDLE,
    SSTM_H_SEND,
    SSTM_H_WAIT
  } sstm_host_phase_t;
endpackage
